// file: core/command_port_device.sv
/*
 * Command interpreter end: decodes command codes, steps through the bytes of
 * the selected register or endpoint buffer, and holds the setup registers.
 * Assumes the processor end on the same mclk drives the link, that wide_bus
 * is static while accesses are in flight, and that the user side supplies
 * receive packet length and data for the selected endpoint.
 */
`include "cmd_port_map.svh"

module command_port_device (
    input wire logic mclk,
    input wire logic rst,
    cmd_port_if.device_end link,
    input wire logic wide_bus,
    output logic [`CP_EP_COUNT*`CP_BYTE_W-1:0] endpoint_setup_reg,
    output logic [`CP_BYTE_W-1:0] function_address_reg,
    output logic [`CP_BYTE_W-1:0] device_mode_reg,
    output logic [`CP_DATA_W-1:0] hardware_setup_reg,
    output logic exec_valid,
    output logic [`CP_BYTE_W-1:0] exec_code,
    output logic tx_valid,
    output logic [`CP_DATA_W-1:0] tx_data,
    output logic [1:0] tx_count,
    output logic [`CP_EP_FIELD_W-1:0] tx_ep,
    output logic tx_last,
    output logic [`CP_EP_FIELD_W-1:0] rx_ep,
    input wire logic [`CP_DATA_W-1:0] rx_len,
    input wire logic [`CP_DATA_W-1:0] rx_data,
    output logic rx_take,
    output logic [1:0] rx_take_count
);
    import cmd_port_pkg::*;

    localparam int LANES = `CP_DATA_W / `CP_BYTE_W;

    // ============================================================
    // Declarations
    logic q_valid;
    logic q_take;
    logic [$bits(access_type)-1:0] q_bits;
    access_type q;
    logic cmd_acc;
    logic data_acc;
    logic [`CP_BYTE_W-1:0] cmd;
    target_type target;
    logic [`CP_IDX_W-1:0] idx;
    logic [`CP_DATA_W-1:0] pkt_len;
    logic [`CP_BYTE_W-1:0] ep_setup [`CP_EP_COUNT];
    logic [`CP_EP_FIELD_W-1:0] ep;
    logic [`CP_IDX_W-1:0] lane_pos [LANES];
    logic [LANES-1:0] lane_en;
    logic [LANES-1:0] tx_pay;
    logic [LANES-1:0] rx_pay;
    logic [`CP_BYTE_W-1:0] wbyte [LANES];
    logic [`CP_BYTE_W-1:0] rbyte [LANES];
    logic [LANES-1:0] tx_end;
    logic [`CP_IDX_W-1:0] tx_limit;
    logic [`CP_IDX_W-1:0] rx_limit;

    function automatic target_type decode(input logic [`CP_BYTE_W-1:0] code);
        target_type t;
        t = T_EXEC;
        if (code == `CP_CODE_BUF_WRITE_CTRL_OUT || code == `CP_CODE_BUF_READ_CTRL_IN) begin
            t = T_IDLE;
        end else begin
            unique case (code[7:4])
                `CP_GRP_BUF_WRITE: t = T_BUF_W;
                `CP_GRP_BUF_READ: t = T_BUF_R;
                `CP_GRP_CFG_WRITE: t = T_CFG_W;
                `CP_GRP_CFG_READ: t = T_CFG_R;
                default: begin
                    case (code)
                        `CP_CODE_ADDR_WRITE: t = T_ADDR_W;
                        `CP_CODE_ADDR_READ: t = T_ADDR_R;
                        `CP_CODE_MODE_WRITE: t = T_MODE_W;
                        `CP_CODE_MODE_READ: t = T_MODE_R;
                        `CP_CODE_HW_WRITE: t = T_HW_W;
                        `CP_CODE_HW_READ: t = T_HW_R;
                        default: t = T_EXEC;
                    endcase
                end
            endcase
        end
        return t;
    endfunction : decode

    // ============================================================
    // Access buffer; a read waits while the previous answer is unclaimed
    word_buffer #(
        .WIDTH($bits(access_type)),
        .DEPTH(`CP_BUF_DEPTH)
    ) u_access_buffer (
        .mclk(mclk),
        .rst(rst),
        .in_valid(link.acc_valid),
        .in_ready(link.acc_ready),
        .in_data({link.phase_select_line, link.acc_write, link.acc_data}),
        .out_valid(q_valid),
        .out_ready(q_take),
        .out_data(q_bits)
    );

    assign q = access_type'(q_bits);
    assign q_take = q_valid && !(!q.write && link.rsp_valid && !link.rsp_ready);
    assign cmd_acc = q_take && q.phase && q.write;
    assign data_acc = q_take && !q.phase;
    assign ep = cmd[`CP_EP_FIELD_LSB +: `CP_EP_FIELD_W];
    assign tx_limit = `CP_IDX_W'(pkt_len) + `CP_POS_PAYLOAD;
    assign rx_limit = `CP_IDX_W'(rx_len) + `CP_POS_PAYLOAD;

    // ============================================================
    // Per-lane byte positions and read values
    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            // lower lane holds the less significant byte
            lane_pos[l] = idx + `CP_IDX_W'(l);
            // undefined byte of a narrow access is dropped
            lane_en[l] = data_acc && (l == 0 || wide_bus);
            wbyte[l] = q.data[l*`CP_BYTE_W +: `CP_BYTE_W];
            // payload follows the two length bytes
            tx_pay[l] = lane_en[l] && target == T_BUF_W && lane_pos[l] >= `CP_POS_PAYLOAD
                && lane_pos[l] < tx_limit;
            tx_end[l] = tx_pay[l] && (lane_pos[l] + `CP_IDX_W'(1)) == tx_limit;
            rx_pay[l] = lane_en[l] && target == T_BUF_R && lane_pos[l] >= `CP_POS_PAYLOAD
                && lane_pos[l] < rx_limit;
            rbyte[l] = '0;
            if (lane_en[l]) begin
                unique case (target)
                    T_CFG_R: if (lane_pos[l] == `CP_POS_LEN_LO) rbyte[l] = ep_setup[ep];
                    T_ADDR_R: if (lane_pos[l] == `CP_POS_LEN_LO) rbyte[l] = function_address_reg;
                    T_MODE_R: if (lane_pos[l] == `CP_POS_LEN_LO) rbyte[l] = device_mode_reg;
                    T_HW_R: begin
                        if (lane_pos[l] == `CP_POS_LEN_LO) rbyte[l] = hardware_setup_reg[7:0];
                        if (lane_pos[l] == `CP_POS_LEN_HI) rbyte[l] = hardware_setup_reg[15:8];
                    end
                    T_BUF_R: begin
                        if (lane_pos[l] == `CP_POS_LEN_LO) rbyte[l] = rx_len[7:0];
                        if (lane_pos[l] == `CP_POS_LEN_HI) rbyte[l] = rx_len[15:8];
                        if (rx_pay[l]) rbyte[l] = rx_data[l*`CP_BYTE_W +: `CP_BYTE_W];
                    end
                    default: rbyte[l] = '0;
                endcase
            end
        end
    end

    // ============================================================
    // Command code, target and byte index
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cmd <= `CP_RST_CMD;
            target <= T_IDLE;
            idx <= '0;
        end else if (cmd_acc) begin
            // low byte becomes the code, index restarts
            cmd <= q.data[7:0];
            target <= decode(q.data[7:0]);
            idx <= '0;
        end else if (data_acc) begin
            // a word access steps two bytes
            idx <= idx + (wide_bus ? `CP_IDX_W'(2) : `CP_IDX_W'(1));
        end
    end

    // ============================================================
    // Immediate execution of dataless commands
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            exec_valid <= 1'b0;
            exec_code <= '0;
        end else begin
            exec_valid <= cmd_acc && decode(q.data[7:0]) == T_EXEC;
            if (cmd_acc) begin
                exec_code <= q.data[7:0];
            end
        end
    end

    // ============================================================
    // Setup registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `CP_EP_COUNT; i++) begin
                ep_setup[i] <= `CP_RST_EP_SETUP;
            end
            function_address_reg <= `CP_RST_FUNC_ADDR;
            device_mode_reg <= `CP_RST_DEV_MODE;
            hardware_setup_reg <= `CP_RST_HW_SETUP;
            pkt_len <= '0;
        end else begin
            for (int l = 0; l < LANES; l++) begin
                if (lane_en[l] && lane_pos[l] == `CP_POS_LEN_LO) begin
                    if (target == T_CFG_W) ep_setup[ep] <= wbyte[l];
                    if (target == T_ADDR_W) function_address_reg <= wbyte[l];
                    if (target == T_MODE_W) device_mode_reg <= wbyte[l];
                    if (target == T_HW_W) hardware_setup_reg[7:0] <= wbyte[l];
                    if (target == T_BUF_W) pkt_len[7:0] <= wbyte[l];
                end
                if (lane_en[l] && lane_pos[l] == `CP_POS_LEN_HI) begin
                    if (target == T_HW_W) hardware_setup_reg[15:8] <= wbyte[l];
                    if (target == T_BUF_W) pkt_len[15:8] <= wbyte[l];
                end
            end
        end
    end

    for (genvar g = 0; g < `CP_EP_COUNT; g++) begin : g_setup_out
        assign endpoint_setup_reg[g*`CP_BYTE_W +: `CP_BYTE_W] = ep_setup[g];
    end

    // ============================================================
    // Transmit payload toward USB
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_valid <= 1'b0;
            tx_data <= '0;
            tx_count <= '0;
            tx_ep <= '0;
            tx_last <= 1'b0;
        end else begin
            tx_valid <= |tx_pay;
            // an odd tail counts only the lower byte
            tx_count <= {1'b0, tx_pay[0]} + {1'b0, tx_pay[LANES-1] && LANES > 1};
            tx_last <= |tx_end;
            if (|tx_pay) begin
                tx_data <= q.data;
                tx_ep <= ep;
            end
        end
    end

    // ============================================================
    // Receive payload consumption and answers
    assign rx_ep = ep;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_take <= 1'b0;
            rx_take_count <= '0;
        end else begin
            rx_take <= |rx_pay;
            rx_take_count <= {1'b0, rx_pay[0]} + {1'b0, rx_pay[LANES-1] && LANES > 1};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            link.rsp_valid <= 1'b0;
            link.rsp_data <= '0;
        end else if (q_take && !q.write) begin
            link.rsp_valid <= 1'b1;
            link.rsp_data <= {rbyte[LANES-1] & {`CP_BYTE_W{wide_bus}}, rbyte[0]};
        end else if (link.rsp_ready) begin
            link.rsp_valid <= 1'b0;
        end
    end
endmodule : command_port_device

// file: core/cmd_port_map.svh
/*
 * Holds the command codes, reset values and widths of the peripheral command port.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef CMD_PORT_MAP_SVH
`define CMD_PORT_MAP_SVH

// ============================================================
// Bus and field widths
`define CP_DATA_W 16
`define CP_BYTE_W 8
`define CP_IDX_W 17
`define CP_EP_COUNT 16
`define CP_EP_FIELD_LSB 0
`define CP_EP_FIELD_W 4

// ============================================================
// Command code groups, upper nibble
`define CP_GRP_BUF_WRITE 4'h0
`define CP_GRP_BUF_READ 4'h1
`define CP_GRP_CFG_WRITE 4'h2
`define CP_GRP_CFG_READ 4'h3

// ============================================================
// Single command codes
`define CP_CODE_BUF_WRITE_CTRL_OUT 8'h00
`define CP_CODE_BUF_READ_CTRL_IN 8'h11
`define CP_CODE_ADDR_WRITE 8'hB6
`define CP_CODE_ADDR_READ 8'hB7
`define CP_CODE_MODE_WRITE 8'hB8
`define CP_CODE_MODE_READ 8'hB9
`define CP_CODE_HW_WRITE 8'hBA
`define CP_CODE_HW_READ 8'hBB

// ============================================================
// Byte positions inside a target
`define CP_POS_LEN_LO 17'h00000
`define CP_POS_LEN_HI 17'h00001
`define CP_POS_PAYLOAD 17'h00002

// ============================================================
// Reset values
`define CP_RST_EP_SETUP 8'h00
`define CP_RST_FUNC_ADDR 8'h00
`define CP_RST_DEV_MODE 8'h00
`define CP_RST_HW_SETUP 16'h0000
`define CP_RST_CMD 8'h00

// ============================================================
// Buffer
`define CP_BUF_DEPTH 2

`endif

// file: core/cmd_port_pkg.sv
/*
 * Types shared by both ends of the peripheral command port.
 * Assumes cmd_port_map.svh is on the include path.
 */
`include "cmd_port_map.svh"

package cmd_port_pkg;

    // ============================================================
    // One processor access as carried over the link
    typedef struct packed {
        logic phase;
        logic write;
        logic [`CP_DATA_W-1:0] data;
    } access_type;

    // ============================================================
    // Target selected by the last command, one-hot
    typedef enum logic [11:0] {
        T_IDLE   = 12'h001,
        T_EXEC   = 12'h002,
        T_CFG_W  = 12'h004,
        T_CFG_R  = 12'h008,
        T_ADDR_W = 12'h010,
        T_ADDR_R = 12'h020,
        T_MODE_W = 12'h040,
        T_MODE_R = 12'h080,
        T_HW_W   = 12'h100,
        T_HW_R   = 12'h200,
        T_BUF_W  = 12'h400,
        T_BUF_R  = 12'h800
    } target_type;

endpackage : cmd_port_pkg

// file: core/cmd_port_if.sv
/*
 * Link between the processor end and the command interpreter end.
 * Assumes both ends run on the same mclk; the bench joins them.
 */
`include "cmd_port_map.svh"

interface cmd_port_if;
    logic acc_valid;
    logic acc_ready;
    logic phase_select_line;
    logic acc_write;
    logic [`CP_DATA_W-1:0] acc_data;
    logic rsp_valid;
    logic rsp_ready;
    logic [`CP_DATA_W-1:0] rsp_data;

    modport device_end (
        input acc_valid,
        output acc_ready,
        input phase_select_line,
        input acc_write,
        input acc_data,
        output rsp_valid,
        input rsp_ready,
        output rsp_data
    );

    modport host_end (
        output acc_valid,
        input acc_ready,
        output phase_select_line,
        output acc_write,
        output acc_data,
        input rsp_valid,
        output rsp_ready,
        input rsp_data
    );
endinterface : cmd_port_if

// file: core/word_buffer.sv
/*
 * Small FIFO with valid and ready on both sides and registered full and empty.
 * Assumes a single clock and an asynchronous active-high reset.
 */
`include "cmd_port_map.svh"

module word_buffer #(
    parameter int WIDTH = 18,
    parameter int DEPTH = `CP_BUF_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic full;
    logic empty;
    logic push;
    logic pop;
    logic [PW:0] next_count;

    assign push = in_valid && !full;
    assign pop = out_ready && !empty;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // ============================================================
    // Storage and pointers
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    // ============================================================
    // Occupancy flags kept in flip-flops
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count <= '0;
            full <= 1'b0;
            empty <= 1'b1;
        end else begin
            count <= next_count;
            full <= (next_count == (PW+1)'(DEPTH));
            empty <= (next_count == '0);
        end
    end
endmodule : word_buffer

// file: core/command_port_host.sv
/*
 * Processor end: places user requests on the link one at a time and
 * holds each answer until the user takes it.
 * Assumes the interpreter end on the same mclk answers every read access.
 */
`include "cmd_port_map.svh"

module command_port_host (
    input wire logic mclk,
    input wire logic rst,
    cmd_port_if.host_end link,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_phase,
    input wire logic req_write,
    input wire logic [`CP_DATA_W-1:0] req_data,
    output logic resp_valid,
    input wire logic resp_ready,
    output logic [`CP_DATA_W-1:0] resp_data
);
    import cmd_port_pkg::*;

    logic next_acc_valid;
    logic next_rsp_full;

    // ============================================================
    // Request holding stage
    always_comb begin
        next_acc_valid = link.acc_valid && !link.acc_ready;
        if (req_valid && req_ready) begin
            next_acc_valid = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            link.acc_valid <= 1'b0;
            link.phase_select_line <= 1'b0;
            link.acc_write <= 1'b0;
            link.acc_data <= '0;
            req_ready <= 1'b1;
        end else begin
            link.acc_valid <= next_acc_valid;
            req_ready <= !next_acc_valid;
            if (req_valid && req_ready) begin
                link.phase_select_line <= req_phase;
                link.acc_write <= req_write;
                // code sits in the low byte, upper byte zero
                link.acc_data <= req_phase ? {8'h00, req_data[7:0]} : req_data;
            end
        end
    end

    // ============================================================
    // Answer holding stage
    always_comb begin
        next_rsp_full = resp_valid && !resp_ready;
        if (link.rsp_valid && link.rsp_ready) begin
            next_rsp_full = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            resp_valid <= 1'b0;
            resp_data <= '0;
            link.rsp_ready <= 1'b1;
        end else begin
            resp_valid <= next_rsp_full;
            link.rsp_ready <= !next_rsp_full;
            if (link.rsp_valid && link.rsp_ready) begin
                resp_data <= link.rsp_data;
            end
        end
    end
endmodule : command_port_host

// file: tb/cmd_port_monitor.sv
/*
 * Assertions on the link between the processor end and the interpreter end.
 * Assumes one clock mclk and an asynchronous active-high rst.
 */
module cmd_port_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic acc_valid,
    input wire logic acc_ready,
    input wire logic phase_select_line,
    input wire logic acc_write,
    input wire logic [15:0] acc_data,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [15:0] rsp_data
);
    logic [3:0] pending;
    logic [7:0] last_cmd;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ============================================================
    // Reads awaiting an answer, and the last command code
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pending <= 4'h0;
        end else begin
            pending <= pending + 4'(acc_valid && acc_ready && !acc_write)
                - 4'(rsp_valid && rsp_ready);
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            last_cmd <= 8'h00;
        end else if (acc_valid && acc_ready && phase_select_line && acc_write) begin
            last_cmd <= acc_data[7:0];
        end
    end
    // ============================================================
    // Properties
    sequence s_read_take;
        acc_valid && acc_ready && !acc_write;
    endsequence
    sequence s_answer;
        ##[1:40] rsp_valid;
    endsequence
    property p_read_answer;
        s_read_take |-> s_answer;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read access not answered");
    property p_no_spurious;
        rsp_valid |-> pending != 4'h0;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("answer without a read");
    property p_reset_idle;
        $fell(rst) |-> acc_ready && !rsp_valid;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("link not idle after reset");
    property p_rsp_hold;
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data);
    endproperty
    a_rsp_hold: assert property (p_rsp_hold)
        else $error("answer dropped while stalled");
    property p_acc_hold;
        acc_valid && !acc_ready |=> acc_valid && $stable(acc_data) && $stable(phase_select_line);
    endproperty
    a_acc_hold: assert property (p_acc_hold)
        else $error("access changed while refused");
    property p_cmd_upper;
        acc_valid && phase_select_line |-> acc_data[15:8] == 8'h00;
    endproperty
    a_cmd_upper: assert property (p_cmd_upper)
        else $error("command upper byte not cleared");
    property p_host_single;
        acc_valid && acc_ready |=> !acc_valid;
    endproperty
    a_host_single: assert property (p_host_single)
        else $error("processor end offered accesses back to back");
    property p_byte_upper;
        rsp_valid && (last_cmd == 8'hB7 || last_cmd == 8'hB9 || last_cmd[7:4] == 4'h3)
            |-> rsp_data[15:8] == 8'h00;
    endproperty
    a_byte_upper: assert property (p_byte_upper)
        else $error("one-byte read upper byte not zero");
endmodule : cmd_port_monitor

// file: tb/testbench.sv
/*
 * Self-checking bench: both ends joined by the link, driven from the processor user side.
 * Assumes the design package and header are compiled first.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst = 1, wide_bus = 0, req_valid = 0, req_ready, req_phase = 0;
    logic req_write = 0, resp_valid, resp_ready = 1, exec_valid, tx_valid, tx_last, rx_take;
    logic [15:0] req_data = 0, resp_data, hardware_setup_reg, tx_data;
    logic [15:0] rx_len = 16'h0003, rx_data = 16'h2211;
    logic [127:0] endpoint_setup_reg;
    logic [7:0] function_address_reg, device_mode_reg, exec_code;
    logic [3:0] tx_ep, rx_ep;
    logic [1:0] tx_count, rx_take_count;
    logic [18:0] txq[$];
    int num_errors = 0, samples_checked = 0, rx_bytes = 0;
    cmd_port_if link();
    command_port_device u_command_port_device (.mclk, .rst, .link(link), .wide_bus,
        .endpoint_setup_reg, .function_address_reg, .device_mode_reg, .hardware_setup_reg,
        .exec_valid, .exec_code, .tx_valid, .tx_data, .tx_count, .tx_ep, .tx_last, .rx_ep,
        .rx_len, .rx_data, .rx_take, .rx_take_count);
    command_port_host u_command_port_host (.mclk, .rst, .link(link), .req_valid, .req_ready,
        .req_phase, .req_write, .req_data, .resp_valid, .resp_ready, .resp_data);
    cmd_port_monitor u_cmd_port_monitor (.mclk, .rst, .acc_valid(link.acc_valid),
        .acc_ready(link.acc_ready), .phase_select_line(link.phase_select_line),
        .acc_write(link.acc_write), .acc_data(link.acc_data), .rsp_valid(link.rsp_valid),
        .rsp_ready(link.rsp_ready), .rsp_data(link.rsp_data));
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        if (tx_valid === 1'b1) txq.push_back({tx_last, tx_count, tx_data});
        if (rx_take === 1'b1) rx_bytes += int'(rx_take_count);
    end
    // ============================================================
    // Access tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic send(input logic p, input logic w, input logic [15:0] d);
        int n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk({15'h0, req_ready}, 16'h0001);
        req_valid = 1;
        req_phase = p;
        req_write = w;
        req_data = d;
        @(posedge mclk);
        #1;
        req_valid = 0;
    endtask : send
    task automatic get(input logic [15:0] e);
        int n = 0;
        while (resp_valid !== 1'b1 && n < 60) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk({15'h0, resp_valid}, 16'h0001);
        chk(resp_data, e);
        resp_ready = 1;
        @(posedge mclk);
        #1;
    endtask : get
    task automatic rd(input logic [15:0] e);
        send(0, 0, 16'h0000);
        get(e);
    endtask : rd
    task automatic tally_and_finish;
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // ============================================================
    // Tests
    initial begin
        int n;
        repeat (16) @(posedge mclk);
        #1 rst = 0;
        send(1, 1, 16'h00B7);
        rd(16'h0000);
        send(1, 1, 16'h7EB6);
        send(0, 1, 16'h995A);
        send(1, 1, 16'h00B7);
        rd(16'h005A);
        chk({8'h00, function_address_reg}, 16'h005A);
        send(1, 1, 16'h00BA);
        send(0, 1, 16'h0034);
        send(0, 1, 16'h0012);
        send(0, 1, 16'h0077);
        send(1, 1, 16'h00BB);
        rd(16'h0034);
        rd(16'h0012);
        rd(16'h0000);
        resp_ready = 0;
        send(1, 1, 16'h00B7);
        send(0, 0, 16'h0000);
        send(0, 0, 16'h0000);
        repeat (6) @(posedge mclk);
        #1 get(16'h005A);
        get(16'h0000);
        wide_bus = 1;
        send(1, 1, 16'h00BA);
        send(0, 1, 16'hBEEF);
        send(0, 1, 16'h5555);
        send(1, 1, 16'h00BB);
        rd(16'hBEEF);
        rd(16'h0000);
        chk(hardware_setup_reg, 16'hBEEF);
        send(1, 1, 16'h00B8);
        send(0, 1, 16'hAA3C);
        send(1, 1, 16'h00B9);
        rd(16'h003C);
        chk({8'h00, device_mode_reg}, 16'h003C);
        for (int i = 0; i < 16; i++) begin
            send(1, 1, 16'h0020 + 16'(i));
            send(0, 1, 16'hF080 + 16'(i));
            send(1, 1, 16'h0030 + 16'(i));
            rd(16'h0080 + 16'(i));
            chk({8'h00, endpoint_setup_reg[8*i +: 8]}, 16'h0080 + 16'(i));
        end
        send(1, 1, 16'h00F6);
        n = 0;
        while (exec_valid !== 1'b1 && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk({15'h0, exec_valid}, 16'h0001);
        chk({8'h00, exec_code}, 16'h00F6);
        send(1, 1, 16'h0002);
        send(0, 1, 16'h0003);
        send(0, 1, 16'hBBAA);
        send(0, 1, 16'hEECC);
        n = 0;
        while (txq.size() < 2 && n < 40) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(16'(txq.size()), 16'h0002);
        chk(txq[0][15:0], 16'hBBAA);
        chk({13'h0, txq[0][18:16]}, 16'h0002);
        chk({13'h0, txq[1][18:16]}, 16'h0005);
        chk({8'h00, txq[1][7:0]}, 16'h00CC);
        chk({12'h0, tx_ep}, 16'h0002);
        send(1, 1, 16'h0012);
        rd(16'h0003);
        rd(16'h2211);
        rd(16'h0011);
        chk({12'h0, rx_ep}, 16'h0002);
        chk(16'(rx_bytes), 16'h0003);
        tally_and_finish();
    end
    initial begin
        #200000;
        num_errors++;
        tally_and_finish();
    end
endmodule : testbench
